// ==== aag_map.vh ====
`ifndef AAG_MAP_VH
`define AAG_MAP_VH

// ****************************************
// Register offsets on the plain port
// ****************************************
`define AAG_ADDR_W 4
`define AAG_OFF_ACC 4'h0
`define AAG_OFF_CARRY 4'h1
`define AAG_OFF_LOC_HI 4'h2
`define AAG_OFF_LOC_LO 4'h3
`define AAG_OFF_IW_HI 4'h4
`define AAG_OFF_IW_LO 4'h5
`define AAG_OFF_GO 4'h6
`define AAG_OFF_STATUS 4'h7
`define AAG_OFF_EA_HI 4'h8
`define AAG_OFF_EA_LO 4'h9

// ****************************************
// Memory geometry
// ****************************************
`define AAG_PAGES 64
`define AAG_PAGE_BYTES 256
`define AAG_MADDR_W 14
`define AAG_PAGE_W 6
`define AAG_BYTE_W 8
`define AAG_PAGE_END 8'hFF

// ****************************************
// Instruction classes written to GO
// ****************************************
`define AAG_CLS_SHORT 2'h0
`define AAG_CLS_SHIFT 2'h1
`define AAG_CLS_MEMREF 2'h2

// ****************************************
// Field positions (word bit 15 is the leading bit)
// ****************************************
`define AAG_MR_IND 9
`define AAG_MR_PAGE 8
`define AAG_SF_NZ 2
`define AAG_SF_NC 1
`define AAG_SF_NM 0
`define AAG_SR_CO 10
`define AAG_SR_CI 9
`define AAG_SR_NC 1
`define AAG_SR_NM 0
`define AAG_PTR_STEP 7
`define AAG_PTR_PEND 6

// ****************************************
// Short-form operation codes, word bits 7..3
// ****************************************
`define AAG_OP_NOTHING 5'h07
`define AAG_OP_INC 5'h08
`define AAG_OP_TEST 5'h09
`define AAG_OP_CPL 5'h0A
`define AAG_OP_DBL 5'h0B
`define AAG_OP_ZERO 5'h0C
`define AAG_OP_CSET 5'h0D
`define AAG_OP_CCLR 5'h0E
`define AAG_OP_CINV 5'h0F

// ****************************************
// Shift/rotate operation codes, word bits 15..11
// ****************************************
`define AAG_OP_MOVE 5'h18
`define AAG_OP_ROT 5'h19

// ****************************************
// Reset values and location counter steps
// ****************************************
`define AAG_RST_ACC 8'h00
`define AAG_RST_LOC 14'h0000
`define AAG_RST_IW 16'h0000
`define AAG_STEP_SHORT 14'h0001
`define AAG_STEP_LONG 14'h0002
`define AAG_STEP_SKIP 14'h0002

`endif

// ==== aag_rshift.v ====
`include "aag_map.vh"

// ****************************************
// Right shift or rotate by one to eight places
// ****************************************
module aag_rshift (
  input wire [7:0] din,
  input wire cin,
  input wire [3:0] count,
  input wire rotate,
  input wire ci_sel,
  input wire co_sel,
  output reg [7:0] dout,
  output reg cout
);

  integer i;
  reg bit_out;

  // Step one place at a time so the carry chain behaves per step
  always @* begin
    dout = din;
    cout = cin;
    bit_out = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      if (i < count) begin
        bit_out = dout[0]; // Bit leaving A7
        if (rotate) begin
          dout = {bit_out, dout[7:1]};
        end else if (ci_sel) begin
          dout = {cout, dout[7:1]};
        end else begin
          dout = {1'b0, dout[7:1]};
        end
        if (co_sel) begin
          cout = bit_out;
        end
      end
    end
  end

endmodule

// ==== aag_core.v ====
// Decided for this implementation: the placing of the registers and the plain strobed port.
`include "aag_map.vh"

// How it works
// - Storage is 64 pages of 256 bytes, 16384 bytes total.
// - A 14-bit address: upper six bits page, lower eight bits byte offset.
// - Direct mode uses the address field as offset, page zero or current page.
// - Indirect mode reads a two-byte pointer from page zero or current page.
// - With the step flag set, the pointer offset is incremented before use.
// - Increment touches only the pointer offset; it wraps inside its page.
// - Page-end flag with stepping skips unless the new offset is FF.
// - Page-end flag is ignored when the step flag is clear.
// - Accumulator ops take three skip tests; carry ops take only carry-clear.
// - Short-form skip tests use state from before the operation.
// - increment_acc adds one and loads carry from the top bit.
// - test_and_skip only tests and skips; nothing else changes.
// - complement_accumulator inverts the accumulator, carry unchanged.
// - double_acc adds accumulator to itself, carry from the top bit.
// - zero_acc clears the accumulator after testing, carry unchanged.
// - do_nothing changes nothing and never skips.
// - Carry set, clear, invert after the carry-clear test; accumulator kept.
// - Shifts and rotates move right only, one to eight places, logically.
// - Shift and rotate skip tests use the results after execution.
// - Shift count field holds the ones complement of the distance.
// - logical_right_move: carry out from A7 and carry in to A0, each only when selected.
// - right_rotate feeds A7 into A0, and into carry when selected.
// - A taken skip adds two extra bytes to the location counter.
module aag_core (
  input wire clk,
  input wire rst,
  input wire [3:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata,
  output reg [13:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_wr,
  output reg mem_rd,
  input wire [7:0] mem_rdata,
  output reg busy,
  output reg done
);

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_IDLE = 3'b000;
  localparam [2:0] ST_EXEC = 3'b001;
  localparam [2:0] ST_PTR0 = 3'b010;
  localparam [2:0] ST_PTR1 = 3'b011;
  localparam [2:0] ST_PTR2 = 3'b100;
  localparam [2:0] ST_PTR3 = 3'b101;

  // ****************************************
  // Architectural and control registers
  // ****************************************
  reg [7:0] acc_reg;
  reg carry_reg;
  reg [13:0] loc_reg;
  reg [15:0] iword_reg;
  reg [1:0] class_reg;
  reg [2:0] state_reg;
  reg skip_reg;
  reg bad_reg;
  reg ea_ok_reg;
  reg [13:0] ea_reg;
  reg [13:0] ptr_reg;
  reg [7:0] ptr_hi_reg;

  // ****************************************
  // Short-form datapath
  // ****************************************
  wire [4:0] s_op;
  wire c_nz;
  wire c_nc;
  wire c_nm;
  reg [7:0] s_acc;
  reg s_carry;
  reg s_skip;
  reg s_bad;
  reg [8:0] s_sum;

  assign s_op = iword_reg[7:3];
  // Tests sample the state left by the previous instruction
  assign c_nz = iword_reg[`AAG_SF_NZ] && (acc_reg != 8'h00);
  assign c_nc = iword_reg[`AAG_SF_NC] && !carry_reg;
  assign c_nm = iword_reg[`AAG_SF_NM] && !acc_reg[7];

  // Operation decode; A0 is acc_reg[7], A7 is acc_reg[0]
  always @* begin
    s_acc = acc_reg;
    s_carry = carry_reg;
    s_skip = 1'b0;
    s_bad = 1'b0;
    s_sum = 9'h000;
    case (s_op)
      `AAG_OP_INC: begin
        s_sum = {1'b0, acc_reg} + 9'h001;
        s_acc = s_sum[7:0];
        s_carry = s_sum[8];
        s_skip = c_nz | c_nc | c_nm;
      end
      `AAG_OP_TEST: begin
        s_skip = c_nz | c_nc | c_nm;
      end
      `AAG_OP_CPL: begin
        s_acc = ~acc_reg;
        s_skip = c_nz | c_nc | c_nm;
      end
      `AAG_OP_DBL: begin
        s_sum = {1'b0, acc_reg} + {1'b0, acc_reg};
        s_acc = s_sum[7:0];
        s_carry = s_sum[8];
        s_skip = c_nz | c_nc | c_nm;
      end
      `AAG_OP_ZERO: begin
        s_acc = 8'h00;
        s_skip = c_nz | c_nc | c_nm;
      end
      `AAG_OP_NOTHING: begin
        s_skip = 1'b0;
      end
      // Carry operations honour only the carry-clear test
      `AAG_OP_CSET: begin
        s_carry = 1'b1;
        s_skip = c_nc;
      end
      `AAG_OP_CCLR: begin
        s_carry = 1'b0;
        s_skip = c_nc;
      end
      `AAG_OP_CINV: begin
        s_carry = ~carry_reg;
        s_skip = c_nc;
      end
      default: begin
        s_bad = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Shift/rotate datapath
  // ****************************************
  wire [4:0] r_op;
  wire [2:0] r_cnt_inv;
  wire [3:0] r_count;
  wire [7:0] r_acc;
  wire r_carry;
  wire r_skip;
  wire r_bad;

  assign r_op = iword_reg[15:11];
  assign r_cnt_inv = ~iword_reg[7:5];
  // All-ones field means eight places
  assign r_count = (r_cnt_inv == 3'b000) ? 4'h8 : {1'b0, r_cnt_inv};
  assign r_bad = (r_op != `AAG_OP_MOVE) && (r_op != `AAG_OP_ROT);

  aag_rshift u_rshift (
    .din(acc_reg),
    .cin(carry_reg),
    .count(r_count),
    .rotate(r_op == `AAG_OP_ROT),
    .ci_sel(iword_reg[`AAG_SR_CI]),
    .co_sel(iword_reg[`AAG_SR_CO]),
    .dout(r_acc),
    .cout(r_carry)
  );

  // Tests look at the results
  assign r_skip = (iword_reg[`AAG_SR_NC] && !r_carry) || (iword_reg[`AAG_SR_NM] && !r_acc[7]);

  // ****************************************
  // Address generation
  // ****************************************
  wire [5:0] cur_page;
  wire [5:0] ref_page;
  wire [13:0] direct_ea;
  wire [7:0] ptr_off_inc;
  wire step_flag;
  wire pend_flag;

  assign cur_page = loc_reg[13:8];
  assign ref_page = iword_reg[`AAG_MR_PAGE] ? cur_page : 6'h00;
  assign direct_ea = {ref_page, iword_reg[7:0]};
  assign step_flag = ptr_hi_reg[`AAG_PTR_STEP];
  assign pend_flag = ptr_hi_reg[`AAG_PTR_PEND];
  assign ptr_off_inc = mem_rdata + 8'h01;

  // ****************************************
  // Sequencer, memory port and register port
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= `AAG_RST_ACC;
      carry_reg <= 1'b0;
      loc_reg <= `AAG_RST_LOC;
      iword_reg <= `AAG_RST_IW;
      class_reg <= `AAG_CLS_SHORT;
      state_reg <= ST_IDLE;
      skip_reg <= 1'b0;
      bad_reg <= 1'b0;
      ea_ok_reg <= 1'b0;
      ea_reg <= `AAG_RST_LOC;
      ptr_reg <= `AAG_RST_LOC;
      ptr_hi_reg <= 8'h00;
      bus_rdata <= 8'h00;
      mem_addr <= `AAG_RST_LOC;
      mem_wdata <= 8'h00;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      // Strobes default low
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      done <= 1'b0;
      bus_rdata <= 8'h00;

      // Register reads, data in the following cycle
      if (bus_rd) begin
        if (bus_addr == `AAG_OFF_ACC) begin
          bus_rdata <= acc_reg;
        end else if (bus_addr == `AAG_OFF_CARRY) begin
          bus_rdata <= {7'h00, carry_reg};
        end else if (bus_addr == `AAG_OFF_LOC_HI) begin
          bus_rdata <= {2'b00, loc_reg[13:8]};
        end else if (bus_addr == `AAG_OFF_LOC_LO) begin
          bus_rdata <= loc_reg[7:0];
        end else if (bus_addr == `AAG_OFF_IW_HI) begin
          bus_rdata <= iword_reg[15:8];
        end else if (bus_addr == `AAG_OFF_IW_LO) begin
          bus_rdata <= iword_reg[7:0];
        end else if (bus_addr == `AAG_OFF_STATUS) begin
          bus_rdata <= {4'h0, bad_reg, ea_ok_reg, skip_reg, busy};
        end else if (bus_addr == `AAG_OFF_EA_HI) begin
          bus_rdata <= {2'b00, ea_reg[13:8]};
        end else if (bus_addr == `AAG_OFF_EA_LO) begin
          bus_rdata <= ea_reg[7:0];
        end
      end

      // Register writes are taken only while idle
      if (bus_wr && (state_reg == ST_IDLE)) begin
        if (bus_addr == `AAG_OFF_ACC) begin
          acc_reg <= bus_wdata;
        end else if (bus_addr == `AAG_OFF_CARRY) begin
          carry_reg <= bus_wdata[0];
        end else if (bus_addr == `AAG_OFF_LOC_HI) begin
          loc_reg[13:8] <= bus_wdata[5:0];
        end else if (bus_addr == `AAG_OFF_LOC_LO) begin
          loc_reg[7:0] <= bus_wdata;
        end else if (bus_addr == `AAG_OFF_IW_HI) begin
          iword_reg[15:8] <= bus_wdata;
        end else if (bus_addr == `AAG_OFF_IW_LO) begin
          iword_reg[7:0] <= bus_wdata;
        end else if (bus_addr == `AAG_OFF_GO) begin
          class_reg <= bus_wdata[1:0];
          skip_reg <= 1'b0;
          bad_reg <= 1'b0;
          ea_ok_reg <= 1'b0;
          busy <= 1'b1;
          if ((bus_wdata[1:0] == `AAG_CLS_MEMREF) && iword_reg[`AAG_MR_IND]) begin
            ptr_reg <= direct_ea;
            state_reg <= ST_PTR0;
          end else begin
            state_reg <= ST_EXEC;
          end
        end
      end

      case (state_reg)
        // Fetch pointer byte one
        ST_PTR0: begin
          mem_rd <= 1'b1;
          mem_addr <= ptr_reg;
          state_reg <= ST_PTR1;
        end
        // Fetch pointer byte two, staying in the pointer's page
        ST_PTR1: begin
          mem_rd <= 1'b1;
          mem_addr <= {ptr_reg[13:8], ptr_reg[7:0] + 8'h01};
          state_reg <= ST_PTR2;
        end
        ST_PTR2: begin
          ptr_hi_reg <= mem_rdata;
          state_reg <= ST_PTR3;
        end
        // Offset byte arrives; with the step flag set, step it and write it back
        ST_PTR3: begin
          if (step_flag) begin
            ea_reg <= {ptr_hi_reg[5:0], ptr_off_inc};
            mem_wr <= 1'b1;
            mem_addr <= {ptr_reg[13:8], ptr_reg[7:0] + 8'h01};
            mem_wdata <= ptr_off_inc;
            skip_reg <= pend_flag && (ptr_off_inc != `AAG_PAGE_END);
          end else begin
            ea_reg <= {ptr_hi_reg[5:0], mem_rdata};
            skip_reg <= 1'b0;
          end
          state_reg <= ST_EXEC;
        end
        // Finish and advance the location counter
        ST_EXEC: begin
          state_reg <= ST_IDLE;
          busy <= 1'b0;
          done <= 1'b1;
          if (class_reg == `AAG_CLS_SHORT) begin
            acc_reg <= s_acc;
            carry_reg <= s_carry;
            skip_reg <= s_skip;
            bad_reg <= s_bad;
            loc_reg <= loc_reg + `AAG_STEP_SHORT + (s_skip ? `AAG_STEP_SKIP : 14'h0000);
          end else if (class_reg == `AAG_CLS_SHIFT) begin
            if (!r_bad) begin
              acc_reg <= r_acc;
              carry_reg <= r_carry;
            end
            skip_reg <= r_skip && !r_bad;
            bad_reg <= r_bad;
            loc_reg <= loc_reg + `AAG_STEP_LONG + ((r_skip && !r_bad) ? `AAG_STEP_SKIP : 14'h0000);
          end else if (class_reg == `AAG_CLS_MEMREF) begin
            ea_ok_reg <= 1'b1;
            if (!iword_reg[`AAG_MR_IND]) begin
              ea_reg <= direct_ea;
            end
            loc_reg <= loc_reg + `AAG_STEP_LONG + (skip_reg ? `AAG_STEP_SKIP : 14'h0000);
          end else begin
            bad_reg <= 1'b1;
            loc_reg <= loc_reg + `AAG_STEP_SHORT;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // geometry: 14-bit addresses reach 64 pages of 256 bytes.

endmodule

// ==== aag_mem_model.sv ====
// ****************************************
// Core memory behind the memory port
// ****************************************
module aag_mem_model (
  input wire clk,
  input wire [13:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire mem_wr,
  input wire mem_rd,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:16383];
  initial mem_rdata = 8'h00;
  // Answer a read next cycle; otherwise keep the data lines moving
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (mem_rd) mem_rdata <= mem[mem_addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule

// ==== aag_core_properties.sv ====
// ****************************************
// Port checks for the datapath core
// ****************************************
module aag_core_properties (
  input wire clk,
  input wire rst,
  input wire [3:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_rdata,
  input wire [13:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire mem_wr,
  input wire mem_rd,
  input wire [7:0] mem_rdata,
  input wire busy,
  input wire done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Two pointer byte reads in a row
  sequence ptr_fetch;
    mem_rd && !$past(mem_rd) ##1 mem_rd;
  endsequence
  a_short_go_done: assert property (bus_wr && bus_addr == 4'h6 && !busy && !bus_wdata[1] |=> busy ##1 (done && !busy))
    else $error("short or shift instruction did not end two cycles after start");
  a_ptr_second_byte: assert property (
    ptr_fetch |-> mem_addr == {$past(mem_addr[13:8]), $past(mem_addr[7:0]) + 8'h01})
    else $error("second pointer byte not next offset in same page");
  a_step_write_back: assert property (
    mem_wr |-> mem_addr == $past(mem_addr, 2) && mem_wdata == $past(mem_rdata) + 8'h01)
    else $error("stepped offset not written back to second pointer byte");
  a_step_flag_write: assert property (ptr_fetch ##0 mem_rdata[7] |-> ##2 mem_wr)
    else $error("step flag set but no pointer write");
  a_no_step_write: assert property (ptr_fetch ##0 !mem_rdata[7] |-> ##1 !mem_wr [*2])
    else $error("pointer written with step flag clear");
  a_wr_same_page: assert property (mem_wr |-> mem_addr[13:8] == $past(mem_addr[13:8], 3))
    else $error("pointer write left the pointer page");
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_mem_when_busy: assert property (mem_rd || mem_wr |-> busy)
    else $error("memory strobe while idle");
  a_done_ends_busy: assert property (done |-> !busy && $past(busy))
    else $error("done without a busy period");
  a_carry_one_bit: assert property ($past(bus_rd && bus_addr == 4'h1) |-> bus_rdata[7:1] == 7'h00)
    else $error("carry read shows upper bits");
endmodule
bind aag_core aag_core_properties u_props (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .busy(busy), .done(done));

// ==== acc_ops_and_address_gen_bench.sv ====
`include "aag_map.vh"
// ****************************************
// Self-checking bench for the datapath core
// ****************************************
module acc_ops_and_address_gen_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, bus_wr, bus_rd, mem_wr, mem_rd, busy, done, chk_rd, c, cn, sk;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, mem_wdata, mem_rdata, a, an, nof;
  logic [13:0] mem_addr, loc, pa;
  logic [15:0] w;
  logic [31:0] r;
  logic [4:0] op;
  logic [2:0] m;
  logic [7:0] exp_q[$];
  logic [3:0] adr_q[$];
  int error_cnt = 0, cmp_count = 0, cyc = 0, seed;
  logic [4:0] ops [9] = '{`AAG_OP_NOTHING, `AAG_OP_INC, `AAG_OP_TEST, `AAG_OP_CPL, `AAG_OP_DBL,
    `AAG_OP_ZERO, `AAG_OP_CSET, `AAG_OP_CCLR, `AAG_OP_CINV};
  logic [7:0] b1s [4] = '{8'hC5, 8'hE9, 8'h4C, 8'h93};
  logic [7:0] offs [4] = '{8'hFE, 8'hFF, 8'h37, 8'h10};
  logic [7:0] adrs [4] = '{8'h40, 8'hFF, 8'h21, 8'h80};

  aag_core u_dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .busy(busy), .done(done));
  aag_mem_model u_mem (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata));

  // Clock source
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // Reference arithmetic
  // ****************************************
  function automatic logic [9:0] sf(input logic [7:0] iw, input logic [7:0] x, input logic y);
    logic [8:0] q;
    logic s;
    q = {y, x};
    s = (iw[2] && x != 8'h00) || (iw[1] && !y) || (iw[0] && !x[7]);
    case (iw[7:3])
      `AAG_OP_NOTHING: s = 1'b0;
      `AAG_OP_INC: q = {1'b0, x} + 9'h001;
      `AAG_OP_CPL: q[7:0] = ~x;
      `AAG_OP_DBL: q = {1'b0, x} + {1'b0, x};
      `AAG_OP_ZERO: q[7:0] = 8'h00;
      `AAG_OP_CSET: q[8] = 1'b1;
      `AAG_OP_CCLR: q[8] = 1'b0;
      `AAG_OP_CINV: q[8] = ~y;
      default: ;
    endcase
    return {s, q};
  endfunction
  function automatic logic [9:0] sr(input logic [15:0] iw, input logic [7:0] x, input logic y);
    logic [2:0] f;
    logic b;
    int k;
    f = ~iw[7:5];
    k = (f == 3'h0) ? 8 : int'(f);
    for (int i = 0; i < k; i++) begin
      b = x[0];
      x = {(iw[15:11] == `AAG_OP_ROT) ? b : (iw[9] & y), x[7:1]};
      if (iw[10]) y = b;
    end
    return {(iw[1] && !y) || (iw[0] && !x[7]), y, x};
  endfunction

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= ad;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    bus_rd <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    @(posedge clk);
    bus_addr <= ad;
    bus_rd <= 1'b1;
    bus_wr <= 1'b0;
    adr_q.push_back(ad);
    exp_q.push_back(e);
  endtask
  task automatic run(input logic [1:0] cls, input logic [15:0] iw, input logic [7:0] x, input logic y,
    input logic [13:0] lc);
    int n;
    wr(`AAG_OFF_ACC, x);
    wr(`AAG_OFF_CARRY, {7'h00, y});
    wr(`AAG_OFF_LOC_HI, {2'h0, lc[13:8]});
    wr(`AAG_OFF_LOC_LO, lc[7:0]);
    wr(`AAG_OFF_IW_HI, iw[15:8]);
    wr(`AAG_OFF_IW_LO, iw[7:0]);
    wr(`AAG_OFF_GO, {6'h00, cls});
    wr(`AAG_OFF_ACC, ~x); // Lands while busy, so it must be dropped
    @(posedge clk);
    bus_wr <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 20);
    check("done", 8'h01, {7'h00, done});
  endtask
  task automatic loc_chk(input logic [13:0] e);
    rd(`AAG_OFF_LOC_LO, e[7:0]);
    rd(`AAG_OFF_LOC_HI, {2'h0, e[13:8]});
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Read answers are compared in the cycle after the strobe
  always @(negedge clk) begin
    if (chk_rd === 1'b1) check($sformatf("register %h", adr_q.pop_front()), exp_q.pop_front(), bus_rdata);
    chk_rd = bus_rd;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'h30AA;
    rst = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    chk_rd = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wr(4'hA, 8'h5A);
    for (int i = 0; i < 16; i++) if (i != 6) rd(i[3:0], 8'h00);
    // Every short-form code, all-ones and zero accumulators first
    for (int i = 0; i < 36; i++) begin
      r = $random(seed);
      op = ops[i % 9];
      m = (op == `AAG_OP_NOTHING) ? 3'h0 : (op >= `AAG_OP_CSET) ? (r[2:0] & 3'h2) : r[2:0];
      a = (i < 9) ? 8'hFF : (i < 18) ? 8'h00 : r[15:8];
      c = r[16];
      loc = (i == 0) ? 14'h3FFF : r[31:18];
      {sk, cn, an} = sf({op, m}, a, c);
      run(`AAG_CLS_SHORT, {8'h00, op, m}, a, c, loc);
      rd(`AAG_OFF_ACC, an);
      rd(`AAG_OFF_CARRY, {7'h00, cn});
      rd(`AAG_OFF_STATUS, {6'h00, sk, 1'b0});
      loc_chk(loc + `AAG_STEP_SHORT + (sk ? `AAG_STEP_SKIP : 14'h0000));
    end
    // An unused short-form code changes nothing and raises the bad flag
    run(`AAG_CLS_SHORT, 16'h0087, a, c, loc);
    rd(`AAG_OFF_ACC, a);
    rd(`AAG_OFF_CARRY, {7'h00, c});
    rd(`AAG_OFF_STATUS, 8'h08);
    loc_chk(loc + `AAG_STEP_SHORT);
    // Shifts and rotates over every count with random carry control
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      w = {(i[0] ? `AAG_OP_ROT : `AAG_OP_MOVE), r[1:0], 1'b0, i[3:1], 3'h0, r[3:2]};
      a = r[15:8];
      c = r[16];
      loc = r[31:18];
      {sk, cn, an} = sr(w, a, c);
      run(`AAG_CLS_SHIFT, w, a, c, loc);
      rd(`AAG_OFF_ACC, an);
      rd(`AAG_OFF_CARRY, {7'h00, cn});
      rd(`AAG_OFF_STATUS, {6'h00, sk, 1'b0});
      loc_chk(loc + `AAG_STEP_LONG + (sk ? `AAG_STEP_SKIP : 14'h0000));
    end
    // Direct references in page zero and the current page
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      loc = r[31:18];
      run(`AAG_CLS_MEMREF, {6'h00, 1'b0, i[0], r[7:0]}, r[15:8], r[16], loc);
      rd(`AAG_OFF_EA_HI, i[0] ? {2'h0, loc[13:8]} : 8'h00);
      rd(`AAG_OFF_EA_LO, r[7:0]);
      rd(`AAG_OFF_STATUS, 8'h04);
      loc_chk(loc + `AAG_STEP_LONG);
    end
    // Indirect references: page end, offset wrap, flags ignored
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      loc = r[31:18];
      pa = {i[0] ? loc[13:8] : 6'h00, adrs[i]};
      u_mem.mem[pa] = b1s[i];
      u_mem.mem[{pa[13:8], pa[7:0] + 8'h01}] = offs[i];
      nof = b1s[i][7] ? offs[i] + 8'h01 : offs[i];
      sk = b1s[i][7] && b1s[i][6] && nof != `AAG_PAGE_END;
      run(`AAG_CLS_MEMREF, {6'h00, 1'b1, i[0], adrs[i]}, r[15:8], r[16], loc);
      rd(`AAG_OFF_EA_HI, {2'h0, b1s[i][5:0]});
      rd(`AAG_OFF_EA_LO, nof);
      rd(`AAG_OFF_STATUS, {5'h00, 1'b1, sk, 1'b0});
      loc_chk(loc + `AAG_STEP_LONG + (sk ? `AAG_STEP_SKIP : 14'h0000));
      check("pointer offset", nof, u_mem.mem[{pa[13:8], pa[7:0] + 8'h01}]);
    end
    // Drop the read strobe so no unrequested answer is compared
    @(posedge clk);
    bus_rd <= 1'b0;
    repeat (4) @(posedge clk);
    report_and_stop;
  end
endmodule
